// >>> rtl/dit_params.svh
// Constants for the dual 8-bit cascade interval timer: offsets, fields, resets.
// Assumes a 50 MHz pclk and an APB slave with 32-bit data, one register a word.
`ifndef DIT_PARAMS_SVH
`define DIT_PARAMS_SVH
// Register indices; the byte address is four times the index.
`define DIT_IDX_RUN 6'h20
`define DIT_IDX_LOW_COMPARE_REG 6'h22
`define DIT_IDX_HIGH_COMPARE_REG 6'h23
`define DIT_IDX_MODE 6'h24
`define DIT_IDX_FFCR 6'h25
`define DIT_IDX_STAT 6'h26
// Run control bit positions and writable mask.
`define DIT_RUN_PRE 7
`define DIT_RUN_HIGH 1
`define DIT_RUN_LOW 0
`define DIT_RUN_MASK 8'h83
// Mode register fields.
`define DIT_PAIR_HI 7
`define DIT_PAIR_LO 6
`define DIT_HCLK_HI 3
`define DIT_HCLK_LO 2
`define DIT_LCLK_HI 1
`define DIT_LCLK_LO 0
`define DIT_PAIR_16 2'b01
// Clock select codes.
`define DIT_CLK_SEL0 2'b00
`define DIT_CLK_SEL1 2'b01
`define DIT_CLK_SEL2 2'b10
// Flip-flop control fields and commands.
`define DIT_FF_CMD_HI 3
`define DIT_FF_CMD_LO 2
`define DIT_FF_INV_EN 1
`define DIT_FF_SRC 0
`define DIT_FF_CMD_INV 2'b00
`define DIT_FF_CMD_SET 2'b01
`define DIT_FF_CMD_CLR 2'b10
`define DIT_FF_CMD_KEEP 2'b11
// Reset values and prescaler tap widths.
`define DIT_RST8 8'h00
`define DIT_CNT_MAX 8'hff
`define DIT_PRE_W 11
`define DIT_TAP8_W 3
`define DIT_TAP32_W 5
`define DIT_TAP128_W 7
`endif

// >>> rtl/dit_pkg.sv
// Types shared by the interval timer modules.
// Assumes dit_params.svh supplies the widths.
`default_nettype none
`include "dit_params.svh"
package dit_pkg;
	// State of the prescaler.
	typedef struct packed {
		logic [`DIT_PRE_W-1:0] cnt;
	} dit_pre_t;
	// State of the external input synchroniser.
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} dit_sync_t;
	// State of the timer pair and its bus slave.
	typedef struct packed {
		logic [7:0] run_control_reg;
		logic [7:0] mode_reg;
		logic [7:0] low_compare_reg;
		logic [7:0] high_compare_reg;
		logic inv_en;
		logic invert_source_select;
		logic output_flipflop;
		logic cmp_en;
		logic [7:0] low_up_counter;
		logic [7:0] high_up_counter;
		logic low_timer_irq;
		logic high_timer_irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dit_state_t;
endpackage
`default_nettype wire

// >>> rtl/dit_prescaler.sv
// Prescaler producing the four count taps as one-cycle pulses.
// Assumes the run level comes from a register in the pclk domain.
`default_nettype none
`include "dit_params.svh"
module dit_prescaler (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control.
	input wire logic prescaler_run_bit,
	// Tap pulses.
	output logic tap_div8,
	output logic tap_div32,
	output logic tap_div128,
	output logic tap_div2048
);
	import dit_pkg::*;
	dit_pre_t s_reg; // Current prescaler count.
	dit_pre_t s_next; // Next prescaler count.

	// Count while running, hold at zero while stopped.
	always_comb begin
		s_next = s_reg;
		if (prescaler_run_bit) begin
			s_next.cnt = s_reg.cnt + 1'b1;
		end else begin
			s_next.cnt = '0;
		end
	end

	// Each tap fires when its low bits are all ones.
	assign tap_div8 = prescaler_run_bit && (&s_reg.cnt[`DIT_TAP8_W-1:0]);
	assign tap_div32 = prescaler_run_bit && (&s_reg.cnt[`DIT_TAP32_W-1:0]);
	assign tap_div128 = prescaler_run_bit && (&s_reg.cnt[`DIT_TAP128_W-1:0]);
	assign tap_div2048 = prescaler_run_bit && (&s_reg.cnt);

	// Register the state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dit_edge_sync.sv
// Synchroniser and rising edge detector for the external count input.
// Assumes the input is asynchronous to pclk and slower than pclk / 2.
`default_nettype none
module dit_edge_sync (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Raw input and its edge pulse.
	input wire logic external_count_input,
	output logic rise_pulse
);
	import dit_pkg::*;
	dit_sync_t s_reg; // Synchroniser stages.
	dit_sync_t s_next; // Next stage values.

	// Shift the input through two flops, then keep one more for the edge.
	always_comb begin
		s_next = s_reg;
		s_next.meta = external_count_input;
		s_next.sync = s_reg.meta;
		s_next.last = s_reg.sync;
	end

	// Only the settled stages feed the edge detector.
	assign rise_pulse = s_reg.sync && !s_reg.last;

	// Register the state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dit_timer.sv
// Dual 8-bit interval timer with 16-bit cascade and shared output flip-flop.
// Assumes an APB master on pclk; the external count input may be asynchronous.
//
// Local design decision: the APB interface to the registers.
`default_nettype none
`include "dit_params.svh"
module dit_timer (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins and interrupt requests.
	input wire logic external_count_input,
	output logic timer_output_pin,
	output logic low_timer_irq,
	output logic high_timer_irq
);
	import dit_pkg::*;

	dit_state_t s_reg; // All registered state.
	dit_state_t s_next; // Next value of the state.

	logic tap_div8; // Prescaler tap, pclk / 8.
	logic tap_div32; // Prescaler tap, pclk / 32.
	logic tap_div128; // Prescaler tap, pclk / 128.
	logic tap_div2048; // Prescaler tap, pclk / 2048.
	logic ext_pulse; // Rising edge of the external count input.

	logic run0; // Low timer runs.
	logic run1; // High timer runs.
	logic mode16; // Pair is cascaded.
	logic tick0; // Low counter advance.
	logic tick1; // High counter advance.
	logic match0; // Low comparator match.
	logic match1; // High comparator match in 8-bit mode.
	logic ovf0; // Low counter wraps.
	logic match16; // Joint match in 16-bit mode.
	logic toggle; // Hardware toggle request.
	logic [7:0] hi_val; // High count as seen by the joint compare.
	logic access; // APB access phase.
	logic wr_en; // Write takes effect this edge.
	logic [5:0] idx; // Word index of the access.
	logic aligned; // Byte lane bits of the address are zero.

	// Returns true when an address selects the given register index.
	function automatic logic hit(input logic [7:0] a, input logic [5:0] i);
		return a == {i, 2'b00};
	endfunction

	// Returns a counter value advanced by one, wrapping from the top to zero.
	function automatic logic [7:0] step(input logic [7:0] c);
		return c + 8'h01;
	endfunction

	// Prescaler runs from its own run bit.
	dit_prescaler u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.prescaler_run_bit(s_reg.run_control_reg[`DIT_RUN_PRE]),
		.tap_div8(tap_div8),
		.tap_div32(tap_div32),
		.tap_div128(tap_div128),
		.tap_div2048(tap_div2048)
	);

	// External count input is synchronised before use.
	dit_edge_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.external_count_input(external_count_input),
		.rise_pulse(ext_pulse)
	);

	// Bus decode helpers.
	assign access = psel && penable;
	assign wr_en = access && s_reg.pready && pwrite;
	assign idx = paddr[7:2];
	assign aligned = paddr[1:0] == '0;

	// Mode and run decode.
	assign run0 = s_reg.run_control_reg[`DIT_RUN_LOW];
	assign run1 = s_reg.run_control_reg[`DIT_RUN_HIGH];
	assign mode16 = s_reg.mode_reg[`DIT_PAIR_HI:`DIT_PAIR_LO] == `DIT_PAIR_16;

	// Low timer clock select.
	always_comb begin
		case (s_reg.mode_reg[`DIT_LCLK_HI:`DIT_LCLK_LO])
			`DIT_CLK_SEL0: tick0 = ext_pulse;
			`DIT_CLK_SEL1: tick0 = tap_div8;
			`DIT_CLK_SEL2: tick0 = tap_div32;
			default: tick0 = tap_div128;
		endcase
	end

	// A compare of zero matches when the counter wraps.
	assign match0 = run0 && tick0 && step(s_reg.low_up_counter) == s_reg.low_compare_reg;
	assign ovf0 = run0 && tick0 && s_reg.low_up_counter == `DIT_CNT_MAX;

	// High timer clock: low overflow when cascaded, else the select field.
	always_comb begin
		if (mode16) begin
			tick1 = ovf0;
		end else begin
			case (s_reg.mode_reg[`DIT_HCLK_HI:`DIT_HCLK_LO])
				`DIT_CLK_SEL0: tick1 = match0;
				`DIT_CLK_SEL1: tick1 = tap_div8;
				`DIT_CLK_SEL2: tick1 = tap_div128;
				default: tick1 = tap_div2048;
			endcase
		end
	end

	// High comparator for independent operation.
	assign match1 = run1 && tick1 && step(s_reg.high_up_counter) == s_reg.high_compare_reg;

	// The joint compare sees the high count after a same-cycle carry.
	assign hi_val = (run1 && ovf0) ? step(s_reg.high_up_counter) : s_reg.high_up_counter;
	assign match16 = mode16 && s_reg.cmp_en && match0 && run1 && hi_val == s_reg.high_compare_reg;

	// Select which match toggles the output flip-flop.
	assign toggle = s_reg.inv_en
		&& (mode16 ? match16 : (s_reg.invert_source_select ? match1 : match0));

	// Next-state logic for counters, registers, flip-flop and bus answer.
	always_comb begin
		s_next = s_reg;
		s_next.low_timer_irq = 1'b0;
		s_next.high_timer_irq = 1'b0;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;

		// Low counter: stopped clears, match clears, tick advances.
		if (!run0) begin
			s_next.low_up_counter = `DIT_RST8;
		end else if (mode16 ? match16 : match0) begin
			s_next.low_up_counter = `DIT_RST8;
		end else if (tick0) begin
			s_next.low_up_counter = step(s_reg.low_up_counter);
		end

		// High counter follows the same pattern on its own clock.
		if (!run1) begin
			s_next.high_up_counter = `DIT_RST8;
		end else if (mode16 ? match16 : match1) begin
			s_next.high_up_counter = `DIT_RST8;
		end else if (tick1) begin
			s_next.high_up_counter = step(s_reg.high_up_counter);
		end

		// Interrupt pulses; the low one is silent when cascaded.
		s_next.low_timer_irq = !mode16 && match0;
		s_next.high_timer_irq = mode16 ? match16 : match1;

		// Hardware toggle of the output flip-flop.
		if (toggle) begin
			s_next.output_flipflop = !s_reg.output_flipflop;
		end

		// Register writes take effect at the edge that completes the access.
		if (wr_en) begin
			if (hit(paddr, `DIT_IDX_RUN)) begin
				s_next.run_control_reg = pwdata[7:0] & `DIT_RUN_MASK;
			end
			if (hit(paddr, `DIT_IDX_MODE)) begin
				s_next.mode_reg = pwdata[7:0];
			end
			if (hit(paddr, `DIT_IDX_LOW_COMPARE_REG)) begin
				s_next.low_compare_reg = pwdata[7:0];
				s_next.cmp_en = 1'b0;
			end
			if (hit(paddr, `DIT_IDX_HIGH_COMPARE_REG)) begin
				s_next.high_compare_reg = pwdata[7:0];
				s_next.cmp_en = 1'b1;
			end
			if (hit(paddr, `DIT_IDX_FFCR)) begin
				s_next.inv_en = pwdata[`DIT_FF_INV_EN];
				s_next.invert_source_select = pwdata[`DIT_FF_SRC];
				// Set, clear and invert commands override a toggle in the same cycle; keep lets it through.
				case (pwdata[`DIT_FF_CMD_HI:`DIT_FF_CMD_LO])
					`DIT_FF_CMD_INV: s_next.output_flipflop = !s_reg.output_flipflop;
					`DIT_FF_CMD_SET: s_next.output_flipflop = 1'b1;
					`DIT_FF_CMD_CLR: s_next.output_flipflop = 1'b0;
					default: s_next.output_flipflop = s_next.output_flipflop;
				endcase
			end
		end

		// Answer every access after one wait cycle, with data and error.
		if (access && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.prdata = '0;
			case (idx)
				`DIT_IDX_RUN: s_next.prdata[7:0] = s_reg.run_control_reg;
				`DIT_IDX_MODE: s_next.prdata[7:0] = s_reg.mode_reg;
				`DIT_IDX_FFCR: s_next.prdata[7:0] = {4'h0, `DIT_FF_CMD_KEEP,
					s_reg.inv_en, s_reg.invert_source_select};
				`DIT_IDX_STAT: s_next.prdata[16:0] = {s_reg.output_flipflop,
					s_reg.high_up_counter, s_reg.low_up_counter};
				`DIT_IDX_LOW_COMPARE_REG: s_next.prdata = '0;
				`DIT_IDX_HIGH_COMPARE_REG: s_next.prdata = '0;
				default: s_next.pslverr = 1'b1;
			endcase
			// Byte lane bits set hit no register, so the access is refused.
			if (!aligned) begin
				s_next.pslverr = 1'b1;
				s_next.prdata = '0;
			end
		end
	end

	// Register the state; reset gives stopped, cleared, 8-bit, no inversion.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.cmp_en <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs come straight from the state flops.
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign timer_output_pin = s_reg.output_flipflop;
	assign low_timer_irq = s_reg.low_timer_irq;
	assign high_timer_irq = s_reg.high_timer_irq;

	// All checks below share the bus clock and reset.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A stopped low timer holds zero.
	chk_run_clears_low: assert property (!run0 |=> s_reg.low_up_counter == `DIT_RST8)
		else $error("low counter not cleared while stopped");

	// An 8-bit low match clears the counter and raises the low interrupt.
	chk_low_match_irq: assert property (!mode16 && match0 |=>
		low_timer_irq && s_reg.low_up_counter == `DIT_RST8)
		else $error("low match did not clear and interrupt");

	// The low interrupt never fires in cascaded mode.
	chk_no_low_irq16: assert property (mode16 && match0 |=> !low_timer_irq)
		else $error("low interrupt raised in 16-bit mode");

	// A joint match clears both counters and raises the high interrupt.
	chk_joint_match: assert property (match16 |=> high_timer_irq
		&& s_reg.low_up_counter == `DIT_RST8 && s_reg.high_up_counter == `DIT_RST8)
		else $error("joint match did not clear both counters");

	// A low write disables comparison until the high write.
	chk_cmp_disable: assert property (wr_en && hit(paddr, `DIT_IDX_LOW_COMPARE_REG)
		|=> !s_reg.cmp_en ##1 !match16)
		else $error("comparison not disabled after low write");

	// An inversion command flips the output one edge later.
	chk_cmd_invert: assert property (wr_en && hit(paddr, `DIT_IDX_FFCR)
		&& pwdata[`DIT_FF_CMD_HI:`DIT_FF_CMD_LO] == `DIT_FF_CMD_INV
		|=> timer_output_pin != $past(timer_output_pin))
		else $error("invert command did not flip output");

	// Set and clear commands force the output level.
	chk_cmd_set_clr: assert property (wr_en && hit(paddr, `DIT_IDX_FFCR)
		&& pwdata[`DIT_FF_CMD_HI] != pwdata[`DIT_FF_CMD_LO]
		|=> timer_output_pin == $past(pwdata[`DIT_FF_CMD_LO]))
		else $error("set or clear command ignored");

	// An enabled toggle flips the output when no command intervenes.
	chk_hw_toggle: assert property (toggle && !(wr_en && hit(paddr, `DIT_IDX_FFCR))
		|=> timer_output_pin == !$past(timer_output_pin))
		else $error("match did not toggle output");

	// Compare registers always read back as zero.
	chk_write_only: assert property (access && !pready && !pwrite
		&& (idx == `DIT_IDX_LOW_COMPARE_REG || idx == `DIT_IDX_HIGH_COMPARE_REG)
		|=> pready && prdata == '0 && !pslverr)
		else $error("compare register contents were readable");

	// In cascade the high counter advances on low overflow only.
	chk_cascade_clk: assert property (mode16 && run1 && ovf0 && !match16
		|=> s_reg.high_up_counter == $past(s_reg.high_up_counter) + 8'h01)
		else $error("high counter missed low overflow");

	// An 8-bit high match clears its counter and raises the high interrupt.
	chk_high_match_irq: assert property (!mode16 && match1 |=>
		high_timer_irq && s_reg.high_up_counter == `DIT_RST8)
		else $error("high match did not clear and interrupt");

	// The high interrupt only follows a match of the timer that owns it.
	chk_high_irq_cause: assert property (!(mode16 ? match16 : match1)
		|=> !high_timer_irq)
		else $error("high interrupt without a match");

	// A low tick without a match advances the low counter by one in 8-bit mode.
	chk_low_advance: assert property (!mode16 && tick0 && run0 && !match0
		|=> s_reg.low_up_counter == step($past(s_reg.low_up_counter)))
		else $error("low counter did not advance");

	// A high tick without a match advances the high counter by one in 8-bit mode.
	chk_high_advance: assert property (!mode16 && tick1 && run1 && !match1
		|=> s_reg.high_up_counter == step($past(s_reg.high_up_counter)))
		else $error("high counter did not advance");

	// In cascade a low match alone leaves the low counter running.
	chk_low_no_clear16: assert property (mode16 && match0 && !match16
		|=> s_reg.low_up_counter == step($past(s_reg.low_up_counter)))
		else $error("low counter cleared by a lone low match");

	// In cascade the high counter holds between low overflows.
	chk_high_hold16: assert property (mode16 && run1 && !ovf0 && !match16
		|=> s_reg.high_up_counter == $past(s_reg.high_up_counter))
		else $error("high counter moved without low overflow");

	// Matches of the unselected low timer leave the output alone.
	chk_source_select: assert property (!mode16 && s_reg.invert_source_select
		&& match0 && !match1 && !(wr_en && hit(paddr, `DIT_IDX_FFCR))
		|=> timer_output_pin == $past(timer_output_pin))
		else $error("unselected match toggled output");

	// Writing the high compare turns the joint compare back on.
	chk_cmp_reenable: assert property (wr_en && hit(paddr, `DIT_IDX_HIGH_COMPARE_REG)
		|=> s_reg.cmp_en)
		else $error("comparison not restarted after high write");

	// Only the three run bits can ever be set.
	chk_run_bits_only: assert property (
		(s_reg.run_control_reg & ~`DIT_RUN_MASK) == `DIT_RST8)
		else $error("unused run bit set");

	// A stopped prescaler produces no tap at all.
	chk_stopped_taps: assert property (!s_reg.run_control_reg[`DIT_RUN_PRE]
		|-> !tap_div8 && !tap_div32 && !tap_div128 && !tap_div2048)
		else $error("tap pulse from a stopped prescaler");

	// An edge of the external input counts once, never twice in a row.
	chk_ext_one_pulse: assert property (ext_pulse |=> !ext_pulse)
		else $error("external edge counted twice");
endmodule
`default_nettype wire

// >>> verif/dit_timer_tb.sv
// Self-checking bench for the dual 8-bit interval timer with its APB slave.
// Assumes one wait state on APB, one-cycle irq pulses and a 50 MHz pclk.
`default_nettype none
`include "dit_params.svh"
module dit_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Byte addresses: four times each register index.
	localparam logic [7:0] A_RUN = {`DIT_IDX_RUN, 2'b00};
	localparam logic [7:0] A_LCMP = {`DIT_IDX_LOW_COMPARE_REG, 2'b00};
	localparam logic [7:0] A_HCMP = {`DIT_IDX_HIGH_COMPARE_REG, 2'b00};
	localparam logic [7:0] A_MODE = {`DIT_IDX_MODE, 2'b00};
	localparam logic [7:0] A_FFCR = {`DIT_IDX_FFCR, 2'b00};
	localparam logic [7:0] A_STAT = {`DIT_IDX_STAT, 2'b00};
	// Design inputs.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic external_count_input = 1'b0;
	// Design outputs.
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_output_pin;
	logic low_timer_irq;
	logic high_timer_irq;
	// Bookkeeping.
	int n_fail = 0;
	int compares = 0;
	int n_lirq = 0;
	int n_hirq = 0;
	int cyc = 0;
	int t1, t2, base, k;
	int divl[4] = '{0, 8, 32, 128};
	int divh[4] = '{0, 8, 128, 2048};
	logic [31:0] rdat;
	logic rerr, p0;

	// Clock of 20 ns period.
	always #10 pclk = ~pclk;

	dit_timer dit_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_count_input(external_count_input),
		.timer_output_pin(timer_output_pin), .low_timer_irq(low_timer_irq),
		.high_timer_irq(high_timer_irq));

	// Cycle count, and irq tallies sampled mid-cycle so the edge never races them.
	always @(posedge pclk) cyc <= cyc + 1;
	always @(negedge pclk) begin
		if (low_timer_irq === 1'b1) n_lirq++;
		if (high_timer_irq === 1'b1) n_hirq++;
	end

	// Compares one value and reports a difference at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request is held until the edge that samples pready high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) begin
			n_fail++;
			$display("mismatch at %0t: no pready", $time);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask

	// Lets a command land, then looks at the output pin.
	task automatic pin_is(input logic exp);
		repeat (2) @(negedge pclk);
		check({31'h0, timer_output_pin}, {31'h0, exp});
	endtask

	// Waits, bounded, for the next pulse of one irq and returns its cycle.
	task automatic wait_irq(input logic hi, output int t);
		int i;
		for (i = 0; i < 6000; i++) begin
			@(negedge pclk);
			if ((hi ? high_timer_irq : low_timer_irq) === 1'b1) break;
		end
		if (i == 6000) begin
			n_fail++;
			$display("mismatch at %0t: irq timeout", $time);
		end
		t = cyc;
	endtask

	// Spacing of two successive irq pulses, in pclk cycles.
	task automatic period(input logic hi, input int exp);
		wait_irq(hi, t1);
		wait_irq(hi, t2);
		check(32'(t2 - t1), 32'(exp));
	endtask

	// The pin must change across one further match of the chosen timer.
	task automatic toggles(input logic hi);
		wait_irq(hi, t1);
		@(negedge pclk);
		p0 = timer_output_pin;
		wait_irq(hi, t1);
		@(negedge pclk);
		check({31'h0, timer_output_pin}, {31'h0, ~p0});
	endtask

	// Stop, program mode and compares, then start, in the safe order.
	task automatic setup(input logic [7:0] m, input logic [7:0] lc, input logic [7:0] hc,
		input logic [7:0] run);
		wr(A_RUN, 32'h0);
		wr(A_MODE, {24'h0, m});
		wr(A_LCMP, {24'h0, lc});
		wr(A_HCMP, {24'h0, hc});
		wr(A_RUN, {24'h0, run});
	endtask

	// Closing task: prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (80000) @(posedge pclk);
		n_fail++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end

	// Main sequence.
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		check({31'h0, timer_output_pin}, 32'h0);
		rd(A_RUN, 32'h0);
		rd(A_MODE, 32'h0);
		rd(A_FFCR, 32'h0C);
		rd(A_STAT, 32'h0);
		// Write-only compare, then an unmapped word that must be refused.
		wr(A_LCMP, 32'h5A);
		rd(A_LCMP, 32'h0);
		rd(8'h84, 32'h0);
		check({31'h0, rerr}, 32'h1);
		rd(8'h81, 32'h0);
		check({31'h0, rerr}, 32'h1);
		// Software commands on the output flip-flop with all timers stopped.
		wr(A_FFCR, 32'h04);
		pin_is(1'b1);
		wr(A_FFCR, 32'h08);
		pin_is(1'b0);
		wr(A_FFCR, 32'h00);
		pin_is(1'b1);
		wr(A_FFCR, 32'h00);
		pin_is(1'b0);
		// Prescaler off: a running low timer on a tap must not advance.
		setup(8'h01, 8'h02, 8'h01, 8'h01);
		base = n_lirq;
		repeat (200) @(posedge pclk);
		check(32'(n_lirq - base), 32'h0);
		// Every internal tap of each timer in 8-bit mode.
		for (k = 1; k < 4; k++) begin
			setup(8'(k), 8'h02, 8'h01, 8'h81);
			period(1'b0, 2 * divl[k]);
			setup(8'(k << 2), 8'h02, 8'h01, 8'h82);
			period(1'b1, divh[k]);
		end
		setup(8'h01, 8'h00, 8'h01, 8'h81);
		period(1'b0, 2048);
		// High timer counting low matches, and toggling from each source.
		// Four low matches per high period, so a wrong source nets no change.
		setup(8'h01, 8'h02, 8'h04, 8'h83);
		period(1'b1, 64);
		wr(A_FFCR, 32'h0E);
		toggles(1'b0);
		wr(A_FFCR, 32'h0F);
		toggles(1'b1);
		// Clearing the low run bit stops and clears its counter.
		wr(A_RUN, 32'h82);
		repeat (3) @(posedge pclk);
		apb(1'b0, A_STAT, 32'h0);
		check({24'h0, rdat[7:0]}, 32'h0);
		base = n_lirq;
		repeat (100) @(posedge pclk);
		check(32'(n_lirq - base), 32'h0);
		// External input: five rising edges with compare 3 give one match.
		setup(8'h00, 8'h03, 8'h01, 8'h81);
		base = n_lirq;
		repeat (10) begin
			repeat (4) @(posedge pclk);
			external_count_input <= ~external_count_input;
		end
		repeat (8) @(posedge pclk);
		check(32'(n_lirq - base), 32'h1);
		// Cascade, with the high clock select set to a code it must ignore.
		setup(8'h4D, 8'h02, 8'h01, 8'h83);
		base = n_lirq;
		period(1'b1, 2064);
		check(32'(n_lirq - base), 32'h0);
		toggles(1'b1);
		// Low compare written alone keeps the joint compare off until the high write.
		wr(A_RUN, 32'h80);
		wr(A_LCMP, 32'h02);
		wr(A_RUN, 32'h83);
		base = n_hirq;
		repeat (2300) @(posedge pclk);
		check(32'(n_hirq - base), 32'h0);
		wr(A_HCMP, 32'h02);
		period(1'b1, 4112);
		print_verdict();
	end
endmodule
`default_nettype wire
